// ### rtl/bst_regs.svh
// Constants of the boundary-scan access port: codes, patterns, counts
`ifndef BST_REGS_SVH
`define BST_REGS_SVH

// Instruction register width and codes
`define BST_IR_W 4
`define BST_OP_EXTEST 4'h0
`define BST_OP_SAMPLE 4'h1
`define BST_OP_IDCODE 4'h2
`define BST_OP_RUNBIST 4'h8
`define BST_OP_BYPASS 4'hf

// Fixed pattern loaded on instruction capture
`define BST_IR_CAPTURE 4'h1

// Identification register width and reset contents
`define BST_ID_W 32
// Arbitrary neutral identity value; bit 0 kept at one as a marker
`define BST_ID_DEFAULT 32'h0000_1001

// Self-test length in core clock cycles
`define BST_BIST_CYCLES 1200000

`endif

// ### rtl/bst_pkg.sv
// Types shared by the boundary-scan access port
package bst_pkg;

    // Controller states
    typedef enum logic [3:0] {
        BST_TLR,
        BST_RTI,
        BST_SEL_DR,
        BST_CAP_DR,
        BST_SHIFT_DR,
        BST_EXIT1_DR,
        BST_PAUSE_DR,
        BST_EXIT2_DR,
        BST_UPD_DR,
        BST_SEL_IR,
        BST_CAP_IR,
        BST_SHIFT_IR,
        BST_EXIT1_IR,
        BST_PAUSE_IR,
        BST_EXIT2_IR,
        BST_UPD_IR
    } bst_state_t;

    // Serial test pins as seen by the device
    typedef struct packed {
        logic tms;
        logic tdi;
    } bst_tap_in_t;

    typedef struct packed {
        logic tdo;
        logic tdo_oe;
    } bst_tap_out_t;

endpackage

// ### rtl/bst_tap.sv
// Boundary-scan access port: controller, instructions, data paths, self-test
`timescale 1ns/100ps
`default_nettype none
`include "bst_regs.svh"

// Functional notes
// - Four-bit instruction shifter, serial in at the top, out at bit zero.
// - Instruction capture loads the fixed pattern 0001.
// - Instruction shifter moves one place per rising test clock in shift.
// - Private codes drive the data output with zero during data shift.
// - External test drives pins from cells and captures pin levels.
// - Control cell sets bidirectional direction; cells never reach the core.
// - Sample captures driven outputs and received inputs on rising edge.
// - Data update copies the chain to the pin latch on falling edge.
// - Identification register shifts out; shifted-in bits enter at the top until it reloads outside shift.
// - Bypass code places the one-bit stage in the serial path.
// - An open serial input reads ones, so a broken scan selects bypass.
// - Self-test code selects result bit, sets it to one, arms the test.
// - Self-test starts on first rising edge in run-test idle.
// - Self-test runs its cycle count then leaves zero for pass.
// - Controller moves only on rising test clock or the core reset rst.
// - Logic reset state makes identification the current instruction.
// - Five rising edges with mode high always reach logic reset.
// - Idle holds while mode low, goes to data select when high.
// - Data select goes to capture when low, instruction select when high.
// - Data capture loads the chain only in external test or sample; identification reloads in every non-shift state.
// - Data shift moves the selected register one place toward the output.
// - Instruction update latches the new instruction on falling edge.
// - Bypass stage passes data without inversion.
module bst_tap #(
    parameter int N_IN = 4,
    parameter int N_OUT = 4,
    parameter int N_IO = 4,
    parameter int BIST_CYCLES = `BST_BIST_CYCLES,
    parameter logic [`BST_ID_W-1:0] ID_CODE = `BST_ID_DEFAULT
) (
    // Core clock domain
    input wire logic clk,
    input wire logic rst,
    // Test link, clocked by the test clock
    input wire logic tck,
    input wire bst_pkg::bst_tap_in_t tap_in,
    output var bst_pkg::bst_tap_out_t tap_out,
    // Core side of the pins
    input wire logic [N_OUT-1:0] core_out,
    input wire logic [N_IO-1:0] core_io_out,
    input wire logic core_io_oe,
    output logic [N_IN-1:0] core_in,
    output logic [N_IO-1:0] core_io_in,
    // Package pins
    input wire logic [N_IN-1:0] pin_in,
    input wire logic [N_IO-1:0] pin_io_in,
    output logic [N_OUT-1:0] pin_out,
    output logic [N_IO-1:0] pin_io_out,
    output logic pin_io_oe,
    // Self-test engine
    input wire logic bist_fault,
    output logic bist_run
);
    import bst_pkg::*;

    // Chain layout: inputs low, then bidirectional, outputs, control on top
    localparam int CL = N_IN + N_IO + N_OUT + 1;
    localparam int IO_LO = N_IN;
    localparam int OUT_LO = N_IN + N_IO;
    localparam int CTL = CL - 1;
    localparam int CW = $clog2(BIST_CYCLES + 1);
    localparam logic [CW-1:0] BIST_LAST = CW'(BIST_CYCLES - 1);

    // Elaboration check of the parameters
    if (N_IN < 1 || N_OUT < 1 || N_IO < 1 || BIST_CYCLES < 2) begin
        $error("bst_tap: unsupported parameter values");
    end

    // Rising test clock state
    typedef struct packed {
        bst_state_t state;
        logic [`BST_IR_W-1:0] ir_shift;
        logic pass_bit;
        logic [`BST_ID_W-1:0] id_shift;
        logic result;
        logic armed;
        logic start_t;
        logic [CL-1:0] chain;
        logic [CL-1:0] cap_s1, cap_s2;
        logic done_s1, done_s2, done_s3;
        logic res_s1, res_s2;
    } bst_rise_t;

    // Falling test clock state
    typedef struct packed {
        logic [`BST_IR_W-1:0] inst;
        logic [CL-1:0] latch;
        logic upd_t;
        logic tdo;
        logic tdo_oe;
    } bst_fall_t;

    // Core clock state
    typedef struct packed {
        logic ext_s1, ext_s2;
        logic upd_s1, upd_s2, upd_s3;
        logic [CL-1:0] drive;
        logic [N_IN-1:0] in_s1, in_s2;
        logic [N_IO-1:0] io_s1, io_s2;
        logic [N_OUT-1:0] pin_out;
        logic [N_IO-1:0] pin_io_out;
        logic pin_io_oe;
        logic start_s1, start_s2, start_s3;
        logic [CW-1:0] count;
        logic run;
        logic result;
        logic done_t;
    } bst_core_t;

    bst_rise_t r, next_r;
    bst_fall_t f, next_f;
    bst_core_t c, next_c;
    logic [CL-1:0] cap_raw;
    logic bsel;

    // Pin view presented to the chain capture
    assign cap_raw = {~c.pin_io_oe, c.pin_out, c.io_s2, c.in_s2};
    assign bsel = (f.inst == `BST_OP_EXTEST) || (f.inst == `BST_OP_SAMPLE);

    // Controller and shift paths on the rising test clock
    always_comb begin
        next_r = r;
        next_r.cap_s1 = cap_raw;
        next_r.cap_s2 = r.cap_s1;
        next_r.done_s1 = c.done_t;
        next_r.done_s2 = r.done_s1;
        next_r.done_s3 = r.done_s2;
        next_r.res_s1 = c.result;
        next_r.res_s2 = r.res_s1;
        unique case (r.state)
            BST_TLR: begin
                next_r.state = tap_in.tms ? BST_TLR : BST_RTI;
            end
            BST_RTI: begin
                next_r.state = tap_in.tms ? BST_SEL_DR : BST_RTI;
            end
            BST_SEL_DR: begin
                next_r.state = tap_in.tms ? BST_SEL_IR : BST_CAP_DR;
            end
            BST_CAP_DR: begin
                next_r.state = tap_in.tms ? BST_EXIT1_DR : BST_SHIFT_DR;
            end
            BST_SHIFT_DR: begin
                next_r.state = tap_in.tms ? BST_EXIT1_DR : BST_SHIFT_DR;
            end
            BST_EXIT1_DR: begin
                next_r.state = tap_in.tms ? BST_UPD_DR : BST_PAUSE_DR;
            end
            BST_PAUSE_DR: begin
                next_r.state = tap_in.tms ? BST_EXIT2_DR : BST_PAUSE_DR;
            end
            BST_EXIT2_DR: begin
                next_r.state = tap_in.tms ? BST_UPD_DR : BST_SHIFT_DR;
            end
            BST_UPD_DR: begin
                next_r.state = tap_in.tms ? BST_SEL_DR : BST_RTI;
            end
            BST_SEL_IR: begin
                next_r.state = tap_in.tms ? BST_TLR : BST_CAP_IR;
            end
            BST_CAP_IR: begin
                next_r.state = tap_in.tms ? BST_EXIT1_IR : BST_SHIFT_IR;
            end
            BST_SHIFT_IR: begin
                next_r.state = tap_in.tms ? BST_EXIT1_IR : BST_SHIFT_IR;
            end
            BST_EXIT1_IR: begin
                next_r.state = tap_in.tms ? BST_UPD_IR : BST_PAUSE_IR;
            end
            BST_PAUSE_IR: begin
                next_r.state = tap_in.tms ? BST_EXIT2_IR : BST_PAUSE_IR;
            end
            BST_EXIT2_IR: begin
                next_r.state = tap_in.tms ? BST_UPD_IR : BST_SHIFT_IR;
            end
            BST_UPD_IR: begin
                next_r.state = tap_in.tms ? BST_SEL_DR : BST_RTI;
            end
        endcase
        if (r.state == BST_CAP_IR) begin
            next_r.ir_shift = `BST_IR_CAPTURE;
        end
        if (r.state == BST_SHIFT_IR) begin
            next_r.ir_shift = {tap_in.tdi, r.ir_shift[`BST_IR_W-1:1]};
        end
        if (r.state == BST_CAP_DR && bsel) begin
            next_r.chain = r.cap_s2;
        end
        if (r.state != BST_SHIFT_DR) begin
            next_r.id_shift = ID_CODE;
        end
        if (r.state == BST_SHIFT_DR) begin
            unique case (f.inst)
                `BST_OP_EXTEST, `BST_OP_SAMPLE: begin
                    next_r.chain = {tap_in.tdi, r.chain[CL-1:1]};
                end
                `BST_OP_IDCODE: begin
                    next_r.id_shift = {tap_in.tdi, r.id_shift[`BST_ID_W-1:1]};
                end
                `BST_OP_RUNBIST: begin
                    next_r.result = tap_in.tdi;
                end
                `BST_OP_BYPASS: begin
                    next_r.pass_bit = tap_in.tdi;
                end
                default: next_r.pass_bit = r.pass_bit;
            endcase
        end
        if (r.state == BST_UPD_IR) begin
            next_r.armed = (f.inst == `BST_OP_RUNBIST);
            if (f.inst == `BST_OP_RUNBIST) begin
                next_r.result = 1'b1;
            end
        end
        if (r.state == BST_RTI && r.armed && f.inst == `BST_OP_RUNBIST) begin
            next_r.armed = 1'b0;
            next_r.start_t = ~r.start_t;
        end
        if (r.done_s3 != r.done_s2) begin
            next_r.result = r.res_s2;
        end
    end

    // Rising test clock registers
    always_ff @(posedge tck or posedge rst) begin
        if (rst) begin
            r <= '0;
            r.state <= BST_TLR;
            r.ir_shift <= `BST_IR_CAPTURE;
            r.id_shift <= ID_CODE;
        end else begin
            r <= next_r;
        end
    end

    // Instruction latch, pin latch and serial output on the falling edge
    always_comb begin
        next_f = f;
        next_f.tdo_oe = (r.state == BST_SHIFT_DR) ||
                        (r.state == BST_SHIFT_IR);
        next_f.tdo = 1'b0;
        if (r.state == BST_TLR) begin
            next_f.inst = `BST_OP_IDCODE;
        end
        if (r.state == BST_UPD_IR) begin
            next_f.inst = r.ir_shift;
        end
        if (r.state == BST_UPD_DR && bsel) begin
            next_f.latch = r.chain;
            next_f.upd_t = ~f.upd_t;
        end
        if (r.state == BST_SHIFT_IR) begin
            next_f.tdo = r.ir_shift[0];
        end
        if (r.state == BST_SHIFT_DR) begin
            unique case (f.inst)
                `BST_OP_EXTEST, `BST_OP_SAMPLE: next_f.tdo = r.chain[0];
                `BST_OP_IDCODE: next_f.tdo = r.id_shift[0];
                `BST_OP_RUNBIST: next_f.tdo = r.result;
                `BST_OP_BYPASS: next_f.tdo = r.pass_bit;
                default: next_f.tdo = 1'b0;
            endcase
        end
    end

    // Falling test clock registers
    always_ff @(negedge tck or posedge rst) begin
        if (rst) begin
            f <= '0;
            f.inst <= `BST_OP_IDCODE;
        end else begin
            f <= next_f;
        end
    end

    // Pin drive, pin sampling and self-test counter on the core clock
    always_comb begin
        next_c = c;
        next_c.ext_s1 = (f.inst == `BST_OP_EXTEST);
        next_c.ext_s2 = c.ext_s1;
        next_c.upd_s1 = f.upd_t;
        next_c.upd_s2 = c.upd_s1;
        next_c.upd_s3 = c.upd_s2;
        next_c.in_s1 = pin_in;
        next_c.in_s2 = c.in_s1;
        next_c.io_s1 = pin_io_in;
        next_c.io_s2 = c.io_s1;
        next_c.start_s1 = r.start_t;
        next_c.start_s2 = c.start_s1;
        next_c.start_s3 = c.start_s2;
        // Pin latch is stable when its toggle arrives
        if (c.upd_s3 != c.upd_s2) begin
            next_c.drive = f.latch;
        end
        // Pins follow cells in external test
        if (c.ext_s2) begin
            next_c.pin_out = c.drive[OUT_LO +: N_OUT];
            next_c.pin_io_out = c.drive[IO_LO +: N_IO];
            next_c.pin_io_oe = ~c.drive[CTL];
        end else begin
            next_c.pin_out = core_out;
            next_c.pin_io_out = core_io_out;
            next_c.pin_io_oe = core_io_oe;
        end
        if (c.start_s3 != c.start_s2) begin
            next_c.run = 1'b1;
            next_c.count = '0;
        end else if (c.run) begin
            next_c.count = c.count + CW'(1);
            if (c.count == BIST_LAST) begin
                next_c.run = 1'b0;
                next_c.result = bist_fault;
                next_c.done_t = ~c.done_t;
            end
        end
    end

    // Core clock registers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            c <= '0;
        end else begin
            c <= next_c;
        end
    end

    // Outputs straight from flip-flops
    assign tap_out.tdo = f.tdo;
    assign tap_out.tdo_oe = f.tdo_oe;
    assign core_in = c.in_s2;
    assign core_io_in = c.io_s2;
    assign pin_out = c.pin_out;
    assign pin_io_out = c.pin_io_out;
    assign pin_io_oe = c.pin_io_oe;
    assign bist_run = c.run;

endmodule
`default_nettype wire

// ### bench/bst_tap_asserts.sv
// Port-level checks of the boundary-scan access port, bound to its top
`timescale 1ns/100ps
`default_nettype none
module bst_tap_asserts #(
    parameter int N_IN = 4,
    parameter int N_IO = 4,
    parameter int BIST_CYCLES = 1200000
) (
    // Clocks and reset
    input wire logic clk,
    input wire logic rst,
    input wire logic tck,
    // Test link
    input wire bst_pkg::bst_tap_in_t tap_in,
    input wire bst_pkg::bst_tap_out_t tap_out,
    // Pins, core side and self-test
    input wire logic [N_IN-1:0] pin_in,
    input wire logic [N_IO-1:0] pin_io_in,
    input wire logic [N_IN-1:0] core_in,
    input wire logic [N_IO-1:0] core_io_in,
    input wire logic bist_run
);
    import bst_pkg::*;
    int bist_len;
    logic [1:0] clk_age;

    // Length of the running self-test and core cycles since reset
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            bist_len <= 0;
            clk_age <= 2'h0;
        end else begin
            bist_len <= bist_run ? bist_len + 1 : 0;
            clk_age <= (clk_age == 2'h3) ? clk_age : clk_age + 2'h1;
        end
    end

    // Five high mode bits reach logic reset
    chk_reset_walk: assert property (@(posedge tck) disable iff (rst)
        tap_in.tms [*5] |=> !tap_out.tdo_oe && !tap_out.tdo)
        else $error("five high mode bits left the output enabled");
    // Shift entered only with mode low
    chk_shift_entry: assert property (@(posedge tck)
        disable iff (rst) $rose(tap_out.tdo_oe) |-> !$past(tap_in.tms))
        else $error("shift entered with mode high");
    // Shift left only with mode high
    chk_shift_exit: assert property (@(posedge tck) disable iff (rst)
        $fell(tap_out.tdo_oe) |-> $past(tap_in.tms))
        else $error("shift left with mode low");
    chk_shift_hold: assert property (@(posedge tck) disable iff (rst)
        tap_out.tdo_oe && !tap_in.tms |=> tap_out.tdo_oe)
        else $error("shift stopped with mode low");
    chk_exit_gap: assert property (@(posedge tck) disable iff (rst)
        $fell(tap_out.tdo_oe) |-> !tap_out.tdo_oe [*3])
        else $error("shift re-entered too soon");
    chk_bist_len: assert property (@(posedge clk) disable iff (rst)
        $fell(bist_run) |-> bist_len == BIST_CYCLES)
        else $error("self-test length wrong");
    chk_core_pins: assert property (@(posedge clk) disable iff (rst)
        clk_age[1] |-> core_in == $past(pin_in, 2))
        else $error("core input differs from pin level");
    chk_core_io: assert property (@(posedge clk) disable iff (rst)
        clk_age[1] |-> core_io_in == $past(pin_io_in, 2))
        else $error("core bidirectional input differs from pin level");

    // Main scenarios reached
    cov_bist: cover property (@(posedge clk) $rose(bist_run));
    cov_shift: cover property (@(posedge tck) $rose(tap_out.tdo_oe));
    cov_walk: cover property (@(posedge tck) tap_in.tms [*5]);
endmodule

bind bst_tap bst_tap_asserts #(
    .N_IN(N_IN),
    .N_IO(N_IO),
    .BIST_CYCLES(BIST_CYCLES)
) u_chk (
    .clk(clk), .rst(rst), .tck(tck), .tap_in(tap_in), .tap_out(tap_out),
    .pin_in(pin_in), .pin_io_in(pin_io_in), .core_in(core_in),
    .core_io_in(core_io_in), .bist_run(bist_run)
);
`default_nettype wire

// ### bench/bst_master.sv
// Test-bus master model: makes the test clock, drives mode and data
`timescale 1ns/100ps
`default_nettype none
module bst_master (
    // Test bus toward the device
    output var logic tck,
    output var logic tms,
    output var logic tdi,
    input wire logic tdo
);
    // Idle bus: clock still, data line at its pull-up level
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b1;
    end

    // One test clock period; bits change after the falling edge
    task automatic step(input logic m, input logic d, output logic q);
        tms = m;
        tdi = d;
        #15 tck = 1'b1;
        #16 tck = 1'b0;
        #1 q = tdo;
    endtask

    // Five high mode bits, then low into idle
    task automatic to_idle();
        logic q;
        repeat (5) step(1'b1, 1'b1, q);
        step(1'b0, 1'b1, q);
    endtask

    // Scan n bits, lowest first, from idle back to idle
    task automatic scan(input logic ir, input int n,
                        input logic [31:0] din, output logic [31:0] dout);
        logic q;
        dout = '0;
        step(1'b1, 1'b1, q);
        if (ir) step(1'b1, 1'b1, q);
        step(1'b0, 1'b1, q);
        step(1'b0, 1'b1, q);
        dout[0] = q;
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], q);
            if (i < n - 1) dout[i+1] = q;
        end
        step(1'b1, 1'b1, q);
        step(1'b0, 1'b1, q);
    endtask
endmodule
`default_nettype wire

// ### bench/bst_tap_tb.sv
// Self-checking bench of the boundary-scan access port
`timescale 1ns/100ps
`default_nettype none
`include "bst_regs.svh"
module bst_tap_tb;
    import bst_pkg::*;
    localparam int BIST_N = 20;
    localparam logic [31:0] TB_ID = 32'h0000_a5a5; // Arbitrary identity
    logic clk, rst, tck, tms, tdi, seen;
    logic bist_fault, bist_run, core_io_oe, pin_io_oe;
    logic [3:0] core_out, core_io_out, core_in, core_io_in;
    logic [3:0] pin_in, pin_io_in, pin_out, pin_io_out;
    logic [31:0] got;
    bst_tap_in_t tap_in;
    bst_tap_out_t tap_out;
    int failures, num_checks;

    assign tap_in = {tms, tdi};

    bst_tap #(.BIST_CYCLES(BIST_N), .ID_CODE(TB_ID)) dut (
        .clk(clk), .rst(rst), .tck(tck), .tap_in(tap_in), .tap_out(tap_out),
        .core_out(core_out), .core_io_out(core_io_out),
        .core_io_oe(core_io_oe), .core_in(core_in), .core_io_in(core_io_in),
        .pin_in(pin_in), .pin_io_in(pin_io_in), .pin_out(pin_out),
        .pin_io_out(pin_io_out), .pin_io_oe(pin_io_oe),
        .bist_fault(bist_fault), .bist_run(bist_run)
    );

    bst_master m (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tap_out.tdo));

    // Core clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic check(input logic [31:0] s, input logic [31:0] e);
        num_checks++;
        if (s !== e) begin
            failures++;
            $display("[ERR] %0t seen %h expected %h", $time, s, e);
        end
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Reset both domains, one test clock edge inside it
    task automatic pulse_rst();
        logic q;
        @(posedge clk);
        #1;
        rst = 1'b1;
        fork
            m.step(1'b1, 1'b1, q);
            begin
                repeat (2) @(posedge clk);
                #1;
                rst = 1'b0;
            end
        join
    endtask

    // Load an instruction; the captured pattern comes back first
    task automatic load(input logic [3:0] op);
        m.scan(1'b1, 4, {28'h000_0000, op}, got);
        check(got[3:0], `BST_IR_CAPTURE);
    endtask

    // Identification reads back whole, whatever is shifted in
    task automatic t_idcode();
        repeat (2) begin
            m.scan(1'b0, 32, 32'h0f0f_3c3c, got);
            check(got, TB_ID);
        end
    endtask

    // All-ones scan, as from an open line, selects bypass
    task automatic t_bypass();
        load(4'hf);
        m.scan(1'b0, 8, 32'h0000_00b4, got);
        check(got[7:1], 7'h34);
    endtask

    // Private codes shift only zeros
    task automatic t_private();
        for (int c = 3; c < 15; c++) begin
            if (c != 8) begin
                load(c[3:0]);
                m.scan(1'b0, 8, 32'h0000_00ff, got);
                check(got[7:0], 8'h00);
            end
        end
    endtask

    // Snapshot of pins and core drive, preloading the chain
    task automatic t_sample();
        load(`BST_OP_SAMPLE);
        m.scan(1'b0, 13, 32'h0000_0c96, got);
        check(got[12:0], 13'h035a);
        check(pin_out, 4'h3);
    endtask

    // Preloaded cells drive the pins; pins captured, core untouched
    task automatic t_extest();
        load(`BST_OP_EXTEST);
        repeat (10) @(posedge clk);
        #1;
        check(pin_out, 4'hc);
        check(pin_io_out, 4'h9);
        check(pin_io_oe, 1'b1);
        pin_in = 4'h7;
        // New level needs two core clocks before the capture path sees it
        repeat (3) @(posedge clk);
        #1;
        m.scan(1'b0, 13, 32'h0000_1c96, got);
        check(got[3:0], 4'h7);
        repeat (10) @(posedge clk);
        #1;
        check(pin_io_oe, 1'b0);
        check(core_in, 4'h7);
    endtask

    // Normal drive restored after reset
    task automatic t_normal();
        repeat (4) @(posedge clk);
        #1;
        check(pin_out, 4'h3);
        check(pin_io_out, 4'h6);
    endtask

    // Self-test run; result shifted out afterwards
    task automatic t_bist(input logic fault);
        logic q;
        @(posedge clk);
        #1;
        bist_fault = fault;
        seen = 1'b0;
        load(`BST_OP_RUNBIST);
        // Master holds idle until the run ends
        for (int i = 0; i < 40; i++) begin
            if (bist_run === 1'b1) seen = 1'b1;
            if (seen === 1'b1 && bist_run === 1'b0) break;
            m.step(1'b0, 1'b1, q);
        end
        check({seen, bist_run}, 2'b10);
        if ({seen, bist_run} !== 2'b10) stop_test();
        repeat (3) m.step(1'b0, 1'b1, q);
        m.scan(1'b0, 1, 32'h0000_0001, got);
        check(got[0], fault);
    endtask

    initial begin
        failures = 0;
        num_checks = 0;
        rst = 1'b1;
        seen = 1'b0;
        bist_fault = 1'b0;
        core_out = 4'h3;
        core_io_out = 4'h6;
        core_io_oe = 1'b1;
        pin_in = 4'ha;
        pin_io_in = 4'h5;
        pulse_rst();
        m.to_idle();
        t_idcode();
        t_bypass();
        t_private();
        t_sample();
        t_extest();
        m.to_idle();
        t_idcode();
        // Processor reset after external test, before self-test
        pulse_rst();
        t_normal();
        m.to_idle();
        t_bist(1'b0);
        pulse_rst();
        m.to_idle();
        t_bist(1'b1);
        stop_test();
    end
endmodule
`default_nettype wire
